// ---- rtl/upsc_regs.vh ----
// Purpose: constants for the supply operating-state controller
// Assumes: 50 MHz clock, classic wishbone register access
// Notes:   offsets are byte addresses of aligned 32-bit words
`ifndef UPSC_REGS_VH
`define UPSC_REGS_VH
`define UPSC_CLK_HZ        50000000
`define UPSC_OFF_CTRL      8'h00
`define UPSC_OFF_STATUS    8'h04
`define UPSC_OFF_LEDS      8'h08
`define UPSC_OFF_ALARM     8'h0c
`define UPSC_CTRL_RST      2'h0
`define UPSC_CTRL_PCSEL    0
`define UPSC_CTRL_FAULT    1
`define UPSC_SVC_ENTER_MS  6000
`define UPSC_SVC_EXIT_MS   1000
`define UPSC_DEB_MS        10
`define UPSC_SETTLE_CYC    4'h8
`define UPSC_LEDTEST_MS    500
`define UPSC_FLASH_MS      250
`define UPSC_CYC_PER_MS    (`UPSC_CLK_HZ / 1000)
`define UPSC_SVC_ENTER_CYC (`UPSC_SVC_ENTER_MS * `UPSC_CYC_PER_MS + 1)
`define UPSC_SVC_EXIT_CYC  (`UPSC_SVC_EXIT_MS * `UPSC_CYC_PER_MS + 1)
`define UPSC_DEB_CYC       (`UPSC_DEB_MS * `UPSC_CYC_PER_MS)
`define UPSC_LEDTEST_CYC   (`UPSC_LEDTEST_MS * `UPSC_CYC_PER_MS)
`define UPSC_FLASH_CYC     (`UPSC_FLASH_MS * `UPSC_CYC_PER_MS)
`define UPSC_IND_OFF       2'h0
`define UPSC_IND_ON        2'h1
`define UPSC_IND_FLASH     2'h2
`endif

// ---- rtl/upsc_ctrl.v ----
// Purpose: operating-state control of an uninterruptible dc supply
// Assumes: one 50 MHz clock, synchronous active-high reset, wishbone slave
// Notes:   every pin input is synchronised by two flops before use
`timescale 1ns/1ps
`default_nettype none
`include "upsc_regs.vh"
module upsc_ctrl #(
  parameter SVC_ENTER_CYC = `UPSC_SVC_ENTER_CYC, // service entry hold
  parameter SVC_EXIT_CYC  = `UPSC_SVC_EXIT_CYC,  // service exit hold
  parameter DEB_CYC       = `UPSC_DEB_CYC,       // debounce settle time
  parameter LEDTEST_CYC   = `UPSC_LEDTEST_CYC,   // per led-test phase
  parameter FLASH_CYC     = `UPSC_FLASH_CYC      // half flash period
) (
  input  wire        clk_i,        // system clock
  input  wire        rst_i,        // synchronous reset, high
  input  wire        wb_cyc_i,     // wishbone cycle
  input  wire        wb_stb_i,     // wishbone strobe
  input  wire        wb_we_i,      // wishbone write
  input  wire [7:0]  wb_adr_i,     // wishbone byte address
  input  wire [3:0]  wb_sel_i,     // wishbone byte enables
  input  wire [31:0] wb_dat_i,     // wishbone write data
  output reg  [31:0] wb_dat_o,     // wishbone read data
  output reg         wb_ack_o,     // wishbone acknowledge
  input  wire        vin_ok_i,     // input voltage within range
  input  wire        bat_start_n_i,// battery-start pin, low when shorted
  input  wire        remote_n_i,   // remote pin, low when grounded
  input  wire        svc_btn_i,    // service button, high when pressed
  input  wire        shutdown_i,   // shutdown condition (deep discharge)
  output reg         led_alarm_o,  // red alarm indicator
  output reg         led_bat_o,    // yellow battery-mode indicator
  output reg         led_sgood_o,  // green supply-good indicator
  output reg  [4:0]  led_soc_o,    // charge bar, bit 4 on top
  output reg         sig_alarm_o,  // alarm output, high = no alarm
  output reg         sig_bat_o,    // battery-mode output
  output reg         sig_ready_o,  // ready output
  output reg         load_on_o,    // load supply enable
  output reg         bat_path_o,   // load fed from battery
  output reg         charger_en_o, // internal charger enable
  output reg         bat_conn_o,   // battery terminals connected
  output reg         pc_shdn_o     // pc shutdown request
);
  // one-hot operating states
  localparam [6:0] ST_OFF  = 7'h01;  // waiting for start
  localparam [6:0] ST_INIT = 7'h02;  // led test
  localparam [6:0] ST_MAIN = 7'h04;  // mains operation
  localparam [6:0] ST_BAT  = 7'h08;  // battery operation
  localparam [6:0] ST_SVC  = 7'h10;  // service mode
  localparam [6:0] ST_DOWN = 7'h20;  // load switched off
  localparam [6:0] ST_COLD = 7'h40;  // battery after cold restart
  // state flow in short:
  //   off  -> init   input in range, or a battery-start short with no input
  //   init -> main   after the single lit/dark lamp pass, if started on mains
  //   init -> cold   after the same pass, if started from the battery
  //   main -> bat    input lost and remote inhibit not armed
  //   main -> down   input lost while remote inhibit is armed
  //   main -> svc    button released after the long hold
  //   svc  -> main   button released after the short hold, input present
  //   svc  -> down   input lost: service never falls back to the battery
  //   bat, cold -> main on input, -> down on remote short or shutdown
  //   down -> main   input back
  // the battery path is chosen in the same edge the input loss is seen,
  // so the load enable never drops between mains and battery feed

  // two-flop synchronisers for the five pins
  reg [4:0] sync1_r;  // first stage, read only by second
  reg [4:0] sync2_r;  // second stage
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 5'h1f & 5'h06;
      sync2_r <= 5'h06;
    end else begin
      sync1_r <= {shutdown_i, svc_btn_i, remote_n_i, bat_start_n_i, vin_ok_i};
      sync2_r <= sync1_r;
    end
  end

  // settle window after reset: the debounced lines take the pin levels as
  // they are found and no edge is reported until the pipeline is full, so
  // a contact already closed at power-up is never read as a fresh short
  reg [3:0] settle_r;  // edges since reset, saturating
  wire      armed = (settle_r == `UPSC_SETTLE_CYC); // edges may be reported
  always @(posedge clk_i) begin
    if (rst_i)
      settle_r <= 4'h0;
    else if (!armed)
      settle_r <= settle_r + 4'h1;
  end

  // debounce: output follows the raw level once it stayed for DEB_CYC
  // a level that bounces back before the count ends restarts the wait,
  // which costs DEB_CYC of latency on every contact change
  reg [3:0]  deb_r;     // debounced bat_start_n, remote_n, button, shutdown
  reg [31:0] deb_cnt_r [0:3];
  integer i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      deb_r <= 4'h3;
      for (i = 0; i < 4; i = i + 1)
        deb_cnt_r[i] <= 32'h0;
    end else if (!armed) begin
      deb_r <= sync2_r[4:1];                // take the levels as found
      for (i = 0; i < 4; i = i + 1)
        deb_cnt_r[i] <= 32'h0;
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (sync2_r[i+1] == deb_r[i])
          deb_cnt_r[i] <= 32'h0;            // stable, nothing to do
        else if (deb_cnt_r[i] >= DEB_CYC - 1) begin
          deb_r[i]     <= sync2_r[i+1];
          deb_cnt_r[i] <= 32'h0;
        end else
          deb_cnt_r[i] <= deb_cnt_r[i] + 32'h1;
      end
    end
  end
  wire vin_ok = sync2_r[0];   // monitor is a level, no bounce expected
  wire bst_n  = deb_r[0];
  wire rem_n  = deb_r[1];
  wire btn    = deb_r[2];
  wire shdn   = deb_r[3];

  // edge detection on debounced lines
  reg bst_n_d_r;  // delayed battery-start
  reg rem_n_d_r;  // delayed remote
  reg btn_d_r;    // delayed button
  always @(posedge clk_i) begin
    if (rst_i) begin
      bst_n_d_r <= 1'b1;
      rem_n_d_r <= 1'b1;
      btn_d_r   <= 1'b0;
    end else begin
      bst_n_d_r <= bst_n;
      rem_n_d_r <= rem_n;
      btn_d_r   <= btn;
    end
  end
  // no edge counts inside the settle window after reset
  wire bst_fall = armed & bst_n_d_r & ~bst_n;   // short applied
  wire rem_fall = armed & rem_n_d_r & ~rem_n;   // remote grounded
  wire rem_rise = armed & ~rem_n_d_r & rem_n;   // remote released
  wire btn_rel  = armed & btn_d_r & ~btn;       // button released

  // remote inhibit: latched on transitions only, a level held since
  // reset never arms it, which is why reset clears it
  reg inhibit_r;  // remote inhibit active
  always @(posedge clk_i) begin
    if (rst_i)
      inhibit_r <= 1'b0;
    else if (rem_fall)
      inhibit_r <= 1'b1;
    else if (rem_rise)
      inhibit_r <= 1'b0;
  end

  // button hold timer, saturating
  // saturation keeps a button stuck for hours from wrapping round into a
  // short hold; the hold is only judged when the button is let go
  reg [31:0] hold_r;  // cycles the button has been held
  always @(posedge clk_i) begin
    if (rst_i || !btn)
      hold_r <= 32'h0;
    else if (hold_r != 32'hffffffff)
      hold_r <= hold_r + 32'h1;
  end
  // action on release so a 6 s hold to enter is not also read as exit
  wire hold_enter = btn_rel & (hold_r >= SVC_ENTER_CYC);
  wire hold_exit  = btn_rel & (hold_r >= SVC_EXIT_CYC);

  // wishbone registers
  // register map, one 32-bit word each:
  //   ctrl   rw  bit 0 pc shutdown setting, bit 1 irregularity flag
  //   status ro  bit 9 cold start, bit 8 inhibit, bits 7:1 state, bit 0 input ok
  //   leds   ro  bits 7:3 charge bar, 2 supply good, 1 battery, 0 alarm
  //   alarm  ro  bit 0 alarm active
  // unmapped reads return zero and every access is acknowledged one cycle
  // after it is taken, so a stray address can never stall the bus
  reg [1:0] ctrl_r;   // pc setting select, irregularity flag
  wire      wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r   <= `UPSC_CTRL_RST;
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      // the write lands at the edge where the master sees ack, while it
      // still holds address, select and data
      if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] &&
          wb_adr_i == `UPSC_OFF_CTRL)
        ctrl_r <= wb_dat_i[1:0];
    end
  end
  wire pc_sel = ctrl_r[`UPSC_CTRL_PCSEL];
  wire fault  = ctrl_r[`UPSC_CTRL_FAULT];

  // main state machine
  // the lamp test is one lit phase and one dark phase of LEDTEST_CYC each;
  // it never repeats, and ready is only raised once the dark phase ends
  // cold_r follows the input while idle, so the start cause is captured in
  // the very edge that leaves the idle state
  reg [6:0]  st_r;      // current state
  reg [6:0]  st_nxt;    // next state
  reg        cold_r;    // init started by cold restart
  reg [31:0] tst_cnt_r; // led test phase counter
  reg        tst_ph_r;  // 0 = all lit, 1 = all dark
  wire       tst_done = tst_ph_r & (tst_cnt_r >= LEDTEST_CYC - 1);
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_OFF:  if (vin_ok) st_nxt = ST_INIT;
               else if (bst_fall) st_nxt = ST_INIT;
      ST_INIT: if (tst_done)
                 st_nxt = cold_r ? ST_COLD : ST_MAIN;
      ST_MAIN: if (hold_enter) st_nxt = ST_SVC;
               else if (!vin_ok)
                 st_nxt = inhibit_r ? ST_DOWN : ST_BAT;
      ST_SVC:  if (hold_exit && vin_ok) st_nxt = ST_MAIN;
               else if (!vin_ok) st_nxt = ST_DOWN;
      ST_BAT, ST_COLD:
               if (vin_ok) st_nxt = ST_MAIN;
               else if (rem_fall || shdn) st_nxt = ST_DOWN;
      ST_DOWN: if (vin_ok) st_nxt = ST_MAIN;
      default: st_nxt = ST_OFF;
    endcase
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      st_r      <= ST_OFF;
      cold_r    <= 1'b0;
      tst_cnt_r <= 32'h0;
      tst_ph_r  <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (st_r == ST_OFF)
        cold_r <= ~vin_ok;
      if (st_r != ST_INIT) begin
        tst_cnt_r <= 32'h0;
        tst_ph_r  <= 1'b0;
      end else if (tst_cnt_r >= LEDTEST_CYC - 1) begin
        tst_cnt_r <= 32'h0;
        tst_ph_r  <= 1'b1;                 // single on/off pass
      end else
        tst_cnt_r <= tst_cnt_r + 32'h1;
    end
  end

  // flash and bar animation timebase
  // runs free from reset: flashing lamps and the bar runner share one
  // phase, which keeps all flashing indicators in step with each other
  reg [31:0] fl_cnt_r; // flash divider
  reg        fl_r;     // flash phase
  reg [4:0]  bar_r;    // one-hot top-to-bottom runner
  always @(posedge clk_i) begin
    if (rst_i) begin
      fl_cnt_r <= 32'h0;
      fl_r     <= 1'b0;
      bar_r    <= 5'h10;
    end else if (fl_cnt_r >= FLASH_CYC - 1) begin
      fl_cnt_r <= 32'h0;
      fl_r     <= ~fl_r;
      bar_r    <= (bar_r == 5'h01) ? 5'h10 : {1'b0, bar_r[4:1]};
    end else
      fl_cnt_r <= fl_cnt_r + 32'h1;
  end

  // indicator code to lamp level
  function ind;
    input [1:0] code;
    input       ph;
    begin
      ind = (code == `UPSC_IND_ON) | ((code == `UPSC_IND_FLASH) & ph);
    end
  endfunction

  // output decode, registered
  // lamp and signal levels per state (0 off, 1 lit, B flashing; H/L):
  //   off   0 0 0    alarm L  battery L  ready L  bar dark
  //   init  lamp test alarm H  battery L  ready L
  //   main  0/1 0 1/B alarm H/L battery L ready H  bar full
  //   svc   1 0 1    alarm L  battery L  ready L
  //   bat   0 1 0    alarm H  battery H  ready L
  //   cold  1 1 0    alarm L  battery H  ready L  bar runs top to bottom
  //   down  0 0 0    all low, load off
  // the alarm signal is high while there is no alarm
  reg [1:0] c_al;  // alarm indicator code
  reg [1:0] c_bm;  // battery indicator code
  reg [1:0] c_sg;  // supply-good indicator code
  always @* begin
    c_al = `UPSC_IND_OFF;
    c_bm = `UPSC_IND_OFF;
    c_sg = `UPSC_IND_OFF;
    case (st_r)
      ST_MAIN: begin
        c_al = fault ? `UPSC_IND_ON : `UPSC_IND_OFF;
        c_sg = inhibit_r ? `UPSC_IND_FLASH : `UPSC_IND_ON;
      end
      ST_SVC:  begin
        c_al = `UPSC_IND_ON;
        c_sg = `UPSC_IND_ON;
      end
      ST_BAT:  c_bm = `UPSC_IND_ON;
      ST_COLD: begin
        c_al = `UPSC_IND_ON;
        c_bm = `UPSC_IND_ON;
      end
      default: c_al = `UPSC_IND_OFF;
    endcase
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      led_alarm_o  <= 1'b0;
      led_bat_o    <= 1'b0;
      led_sgood_o  <= 1'b0;
      led_soc_o    <= 5'h00;
      sig_alarm_o  <= 1'b0;
      sig_bat_o    <= 1'b0;
      sig_ready_o  <= 1'b0;
      load_on_o    <= 1'b0;
      bat_path_o   <= 1'b0;
      charger_en_o <= 1'b0;
      bat_conn_o   <= 1'b0;
      pc_shdn_o    <= 1'b0;
      wb_dat_o     <= 32'h0;
    end else begin
      led_alarm_o  <= (st_r == ST_INIT) ? ~tst_ph_r : ind(c_al, fl_r);
      led_bat_o    <= (st_r == ST_INIT) ? ~tst_ph_r : ind(c_bm, fl_r);
      led_sgood_o  <= (st_r == ST_INIT) ? ~tst_ph_r : ind(c_sg, fl_r);
      led_soc_o    <= (st_r == ST_INIT) ? {5{~tst_ph_r}} :
                      (st_r == ST_COLD) ? bar_r :
                      (st_r == ST_MAIN) ? 5'h1f : 5'h00;
      sig_alarm_o  <= (st_r == ST_INIT) | ((st_r == ST_MAIN) & ~fault) |
                      (st_r == ST_BAT);
      sig_bat_o    <= (st_r == ST_BAT) | (st_r == ST_COLD);
      sig_ready_o  <= (st_r == ST_MAIN);
      load_on_o    <= (st_r == ST_MAIN) | (st_r == ST_BAT) | (st_r == ST_COLD) |
                      (st_r == ST_SVC);
      bat_path_o   <= (st_r == ST_BAT) | (st_r == ST_COLD);
      charger_en_o <= (st_r == ST_MAIN);
      bat_conn_o   <= (st_r != ST_SVC) & (st_r != ST_OFF);
      pc_shdn_o    <= pc_sel & ((st_r == ST_BAT) | (st_r == ST_COLD));
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `UPSC_OFF_CTRL:   wb_dat_o <= {30'h0, ctrl_r};
          `UPSC_OFF_STATUS: wb_dat_o <= {22'h0, cold_r, inhibit_r, st_r, vin_ok};
          `UPSC_OFF_LEDS:   wb_dat_o <= {24'h0, led_soc_o, led_sgood_o, led_bat_o,
                                         led_alarm_o};
          `UPSC_OFF_ALARM:  wb_dat_o <= {31'h0, ~sig_alarm_o};
          default:          wb_dat_o <= 32'h0;
        endcase
      end
    end
  end
endmodule // upsc_ctrl
`default_nettype wire

// ---- tb/upsc_user_model.sv ----
// Purpose: user contacts and service button facing the controller
// Assumes: pins change right after a rising edge
// Notes:   contacts idle open (high), button idle released
`timescale 1ns/1ps
`default_nettype none
module upsc_user_model (
  input  wire logic clk_i,         // system clock
  output var  logic bat_start_n_o, // battery-start contact
  output var  logic remote_n_o,    // remote contact
  output var  logic svc_btn_o      // service button
);
  initial begin
    bat_start_n_o = 1'b1;
    remote_n_o    = 1'b1;
    svc_btn_o     = 1'b0;
  end
  // short pulse, longer than the debounce so it is not lost
  task pulse_bat();
    bat_start_n_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    bat_start_n_o <= 1'b1;
  endtask
  // hold length decides entry or exit of service mode
  task hold_btn(input int n);
    svc_btn_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    svc_btn_o <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  task set_remote(input logic v);
    remote_n_o <= v;
    repeat (8) @(posedge clk_i);
  endtask
endmodule // upsc_user_model
`default_nettype wire

// ---- tb/upsc_ctrl_checker.sv ----
// Purpose: port-level checks of the operating-state controller
// Assumes: one clock, synchronous active-high reset
// Notes:   state is inferred from the output pattern only
`timescale 1ns/1ps
`default_nettype none
module upsc_ctrl_checker (
  input wire logic        clk_i,        // clock
  input wire logic        rst_i,        // reset
  input wire logic        wb_cyc_i,     // bus cycle
  input wire logic        wb_stb_i,     // bus strobe
  input wire logic        wb_we_i,      // bus write
  input wire logic [7:0]  wb_adr_i,     // bus address
  input wire logic [31:0] wb_dat_o,     // read data
  input wire logic        wb_ack_o,     // acknowledge
  input wire logic        led_alarm_o,  // alarm led
  input wire logic        led_bat_o,    // battery led
  input wire logic        sig_alarm_o,  // alarm output
  input wire logic        sig_bat_o,    // battery output
  input wire logic        sig_ready_o,  // ready output
  input wire logic        load_on_o,    // load enable
  input wire logic        bat_path_o,   // battery feed
  input wire logic        charger_en_o, // charger enable
  input wire logic        bat_conn_o,   // battery connected
  input wire logic        pc_shdn_o     // pc shutdown
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_late: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_unmapped_rd_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h0c
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_bat_feed_ok: assert property (bat_path_o |-> load_on_o && bat_conn_o)
    else $error("battery feed without load or terminals");
  a_bat_show: assert property (bat_path_o |-> sig_bat_o && led_bat_o)
    else $error("battery mode not shown");
  a_pc_only_bat: assert property (pc_shdn_o |-> bat_path_o || $past(bat_path_o))
    else $error("pc shutdown outside battery mode");
  a_ready_load_on: assert property (sig_ready_o |-> load_on_o)
    else $error("ready without load supply");
  a_charger_conn: assert property (charger_en_o |-> bat_conn_o)
    else $error("charger on with terminals open");
  a_svc_alarm_on: assert property (load_on_o && !bat_conn_o |->
    led_alarm_o && !sig_alarm_o) else $error("service without alarm");
  c_bat: cover property (bat_path_o);
  c_pc: cover property (pc_shdn_o);
  c_svc: cover property (load_on_o && !bat_conn_o);
endmodule // upsc_ctrl_checker
bind upsc_ctrl upsc_ctrl_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .led_alarm_o(led_alarm_o), .led_bat_o(led_bat_o),
  .sig_alarm_o(sig_alarm_o), .sig_bat_o(sig_bat_o), .sig_ready_o(sig_ready_o),
  .load_on_o(load_on_o), .bat_path_o(bat_path_o), .charger_en_o(charger_en_o),
  .bat_conn_o(bat_conn_o), .pc_shdn_o(pc_shdn_o));
`default_nettype wire

// ---- tb/upsc_ctrl_tb.sv ----
// Purpose: self-checking bench of the operating-state controller
// Assumes: shortened counts 60,20,3,10,4 cycles
// Notes:   state is polled through the status register
`timescale 1ns/1ps
`default_nettype none
`include "upsc_regs.vh"
module upsc_ctrl_tb;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, vin = 0, shdn = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0, rdat, q;
  wire logic [4:0] soc;
  wire logic a_l, b_l, g_l, s_a, s_b, s_r, ld, bp, ch, bc, pc, ack, bs_n, rm_n, btn;
  int errors = 0, n_compared = 0, hi;
  always #10 clk_i = ~clk_i;
  upsc_user_model u_upsc_user_model (.clk_i(clk_i), .bat_start_n_o(bs_n),
    .remote_n_o(rm_n), .svc_btn_o(btn));
  upsc_ctrl #(.SVC_ENTER_CYC(60), .SVC_EXIT_CYC(20), .DEB_CYC(3), .LEDTEST_CYC(10),
    .FLASH_CYC(4)) u_upsc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .vin_ok_i(vin), .bat_start_n_i(bs_n),
    .remote_n_i(rm_n), .svc_btn_i(btn), .shutdown_i(shdn), .led_alarm_o(a_l),
    .led_bat_o(b_l), .led_sgood_o(g_l), .led_soc_o(soc), .sig_alarm_o(s_a),
    .sig_bat_o(s_b), .sig_ready_o(s_r), .load_on_o(ld), .bat_path_o(bp),
    .charger_en_o(ch), .bat_conn_o(bc), .pc_shdn_o(pc));
  task report_and_stop();
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // classic cycle: hold everything until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk_i);
  endtask
  // poll status until the one-hot state field matches
  task wait_st(input logic [6:0] e);
    int k;
    k = 0;
    wb(0, `UPSC_OFF_STATUS, 0);
    while (q[7:1] !== e && k < 300) begin wb(0, `UPSC_OFF_STATUS, 0); k++; end
    chk("state", e, q[7:1]);
  endtask
  task t_startup();
    repeat (10) @(posedge clk_i);
    wait_st(7'h01);
    vin <= 1;
    while ({a_l, b_l, g_l, soc} !== 8'hff) @(posedge clk_i);
    while ({a_l, b_l, g_l, soc} !== 8'h00) @(posedge clk_i);
    wait_st(7'h04);
    chk("ready", 3'b111, {s_r, ld, g_l});
  endtask
  task t_bus();
    wb(0, 8'h10, 0);
    chk("unmapped", 0, q);
    wb(1, `UPSC_OFF_STATUS, 32'hffffffff);
    wait_st(7'h04);
    sel <= 4'h0;
    wb(1, `UPSC_OFF_CTRL, 32'h3);
    sel <= 4'hf;
    wb(0, `UPSC_OFF_CTRL, 0);
    chk("sel_off", 0, q);
  endtask
  task t_fail_pc();
    vin <= 0;
    wait_st(7'h08);
    chk("bat", 2'b11, {bp, ld});
    wb(1, `UPSC_OFF_CTRL, 1);
    repeat (3) @(posedge clk_i);
    chk("pc", 1, pc);
    wb(1, `UPSC_OFF_CTRL, 0);
    vin <= 1;
    wait_st(7'h04);
    vin <= 0;
    wait_st(7'h08);
    shdn <= 1;
    wait_st(7'h20);
    chk("shdn_off", 2'b00, {ld, bp});
    shdn <= 0;
    vin <= 1;
    wait_st(7'h04);
  endtask
  task t_fault();
    wb(1, `UPSC_OFF_CTRL, 2);
    wb(0, `UPSC_OFF_ALARM, 0);
    chk("alarm", 1, q[0]);
    chk("alarm_led", 1, a_l);
    wb(1, `UPSC_OFF_CTRL, 0);
  endtask
  task t_service();
    u_upsc_user_model.hold_btn(70);
    wait_st(7'h10);
    chk("svc_out", 3'b100, {a_l, ch, bc});
    u_upsc_user_model.hold_btn(30);
    wait_st(7'h04);
    u_upsc_user_model.hold_btn(70);
    wait_st(7'h10);
    vin <= 0;
    wait_st(7'h20);
    chk("svc_fail", 0, bp);
    vin <= 1;
    wait_st(7'h04);
  endtask
  task t_remote();
    u_upsc_user_model.set_remote(0);
    wb(0, `UPSC_OFF_STATUS, 0);
    chk("inhibit", 1, q[8]);
    hi = 0;
    repeat (20) begin @(posedge clk_i); hi += g_l; end
    chk("flash", 1, hi > 0 && hi < 20);
    vin <= 0;
    wait_st(7'h20);
    chk("load_off", 2'b00, {ld, bp});
    u_upsc_user_model.set_remote(1);
    vin <= 1;
    wait_st(7'h04);
  endtask
  task t_cold();
    vin <= 0;
    u_upsc_user_model.set_remote(0);
    rst_i <= 1;
    repeat (4) @(posedge clk_i);
    chk("rst_out", 0, {ld, bp, s_r, ch, bc, pc});
    rst_i <= 0;
    repeat (10) @(posedge clk_i);
    u_upsc_user_model.pulse_bat();
    wait_st(7'h40);
    chk("cold", 7'h65, {a_l, b_l, g_l, s_a, s_b, s_r, ld});
    chk("no_inh", 0, q[8]);
    hi = 0;
    while (soc !== 5'h10 && hi < 40) begin @(posedge clk_i); hi++; end
    repeat (4) @(posedge clk_i);
    chk("bar_step", 5'h08, soc);
    u_upsc_user_model.set_remote(1);
    u_upsc_user_model.set_remote(0);
    wait_st(7'h20);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    t_startup();
    t_bus();
    t_fail_pc();
    t_fault();
    t_service();
    t_remote();
    t_cold();
    report_and_stop();
  end
  // cut a hang short well after the expected run
  initial begin
    repeat (60000) @(posedge clk_i);
    errors++;
    report_and_stop();
  end
endmodule // upsc_ctrl_tb
`default_nettype wire
